// File: dv/llec_event_counters_tb.sv
// self-checking bench for the link layer event counters
`timescale 1ns/1ps

module llec_event_counters_tb;

    // ========================================
    // stimulus and observation signals
    logic        sys_clk         = 1'b0;
    logic        rst_n           = 1'b0;
    logic [7:0]  avs_address     = 8'h00;
    logic        avs_read        = 1'b0;
    logic        avs_write       = 1'b0;
    logic [31:0] avs_writedata   = 32'h0;
    logic [31:0] avs_readdata;
    logic        avs_waitrequest;
    logic [1:0]  trig            = 2'h0;
    logic [4:0]  pkt             = 5'h0;
    logic [1:0]  shut            = 2'h0;
    logic [31:0] rd;
    int          n_mismatch      = 0;
    int          checks_done     = 0;
    // candidate outcomes as {credits ok, table set}: success first
    logic [1:0]  oc [4]          = '{2'h3, 2'h1, 2'h2, 2'h0};
    logic [1:0]  tseq [6]        = '{2'h1, 2'h2, 2'h3, 2'h3, 2'h0, 2'h3};
    logic [1:0]  sseq [7]        = '{2'h1, 2'h1, 2'h0, 2'h3, 2'h2, 2'h2, 2'h1};
    logic [7:0]  mlist [5]       = '{8'h01, 8'h02, 8'h04, 8'h08, 8'h0f};
    logic [31:0] mexp [5]        = '{32'h1, 32'h2, 32'h3, 32'h4, 32'ha};
    logic [31:0] texp [4]        = '{32'h8, 32'h2, 32'h8, 32'h2};
    logic [31:0] sexp [4]        = '{32'h4, 32'h3, 32'h3, 32'h1};

    llec_event_counters dut (
        .sys_clk                 (sys_clk),
        .rst_n                   (rst_n),
        .avs_address             (avs_address),
        .avs_read                (avs_read),
        .avs_write               (avs_write),
        .avs_writedata           (avs_writedata),
        .avs_readdata            (avs_readdata),
        .avs_waitrequest         (avs_waitrequest),
        .cluster_trigger_output  (trig),
        .pkt_valid               (pkt[4]),
        .pkt_data_response_class (pkt[3]),
        .pkt_to_caching_agent    (pkt[2]),
        .egress_credits_ok       (pkt[1]),
        .route_back_table_set    (pkt[0]),
        .link_shutdown_state_tx  (shut[0]),
        .link_shutdown_state_rx  (shut[1])
    );

    initial begin
        forever #5 sys_clk = ~sys_clk;
    end

    // ========================================
    // helpers
    task automatic conclude();
        if (n_mismatch == 0 && checks_done > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    task automatic fail(input string msg);
        n_mismatch++;
        $display("FAIL at %0t: %s", $time, msg);
    endtask

    task automatic cmp32(input logic [31:0] got, input logic [31:0] exp,
                         input string what);
        checks_done++;
        if (got !== exp)
            fail($sformatf("%s got %h exp %h", what, got, exp));
    endtask

    task automatic chk(input logic ok, input string what);
        checks_done++;
        if (ok !== 1'b1)
            fail(what);
    endtask

    function automatic logic [7:0] a_sel(input int i);
        return llec_pkg::OFS_SEL_BASE + 8'(4 * i);
    endfunction

    function automatic logic [7:0] a_lo(input int i);
        return llec_pkg::OFS_CTR_LO + 8'(4 * i);
    endfunction

    function automatic logic [31:0] mk_sel(input logic [7:0] code,
                                           input logic [7:0] um,
                                           input logic x, input logic e);
        logic [31:0] v;
        v = {8'h00, 8'h00, um, code};
        v[llec_pkg::SEL_EXTRA_BIT] = x;
        v[llec_pkg::SEL_EDGE_BIT]  = e;
        v[llec_pkg::SEL_EN_BIT]    = 1'b1;
        return v;
    endfunction

    // holds the request until waitrequest is sampled low
    task automatic bus(input logic wr, input logic [7:0] a,
                       input logic [31:0] d);
        int n;
        @(posedge sys_clk);
        avs_address   <= a;
        avs_writedata <= d;
        avs_write     <= wr;
        avs_read      <= ~wr;
        n = 0;
        do begin
            @(posedge sys_clk);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 20);
        if (avs_waitrequest !== 1'b0) begin
            fail("bus access never answered");
            conclude();
        end
        rd = avs_readdata;
        avs_write <= 1'b0;
        avs_read  <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        bus(1'b1, a, d);
    endtask

    task automatic rdc(input logic [7:0] a, input logic [31:0] exp,
                       input string what);
        bus(1'b0, a, 32'h0);
        cmp32(rd, exp, what);
    endtask

    task automatic ev(input logic [1:0] t, input logic [4:0] p,
                      input logic [1:0] s);
        @(posedge sys_clk);
        trig <= t;
        pkt  <= p;
        shut <= s;
    endtask

    initial begin
        repeat (100000) @(posedge sys_clk);
        fail("watchdog expired");
        conclude();
    end

    // ========================================
    // main sequence
    initial begin
        repeat (20) @(posedge sys_clk);
        rst_n <= 1'b1;
        for (int i = 0; i < 4; i++) begin
            rdc(a_sel(i), 32'h0, "select reset");
            rdc(a_lo(i), 32'h0, "counter reset");
        end
        rdc(llec_pkg::OFS_INFO, {16'h0, 8'h30, llec_pkg::LINK_CLK_DIV},
            "info");
        wr(8'h3c, 32'hffff_ffff);
        rdc(8'h3c, 32'h0, "unmapped");
        wr(a_sel(0), 32'hffff_ffff);
        rdc(a_sel(0), llec_pkg::SEL_WR_MASK, "select mask");
        wr(a_sel(0), mk_sel(llec_pkg::EVT_LINK_CLOCK_TICK, 8'h00, 0, 0));
        repeat (50) @(posedge sys_clk);
        wr(a_sel(0), 32'h0);
        bus(1'b0, a_lo(0), 32'h0);
        // enabled from the edge after the first write to the one
        // that takes the second: 1 + 50 + 2 counted edges
        cmp32(rd, 32'h35, "tick count");
        // trigger count, plain on even counters, edge on odd ones
        for (int i = 0; i < 4; i++) begin
            wr(a_lo(i), 32'h0);
            wr(a_sel(i), mk_sel(llec_pkg::EVT_TRIGGER_OUTPUT, 8'h00, 1,
                                i[0]));
        end
        foreach (tseq[j]) ev(tseq[j], 5'h0, 2'h0);
        ev(2'h0, 5'h0, 2'h0);
        for (int i = 0; i < 4; i++) begin
            wr(a_sel(i), 32'h0);
            rdc(a_lo(i), texp[i], "trigger");
        end
        // wrap: full counter plus two triggers lands on one
        wr(a_lo(1), 32'hffff_ffff);
        wr(llec_pkg::OFS_CTR_HI + 8'h04, 32'hffff_ffff);
        rdc(llec_pkg::OFS_CTR_HI + 8'h04, 32'h0000_ffff, "hi");
        wr(a_sel(1), mk_sel(llec_pkg::EVT_TRIGGER_OUTPUT, 8'h00, 1, 0));
        ev(2'h3, 5'h0, 2'h0);
        ev(2'h0, 5'h0, 2'h0);
        wr(a_sel(1), 32'h0);
        rdc(a_lo(1), 32'h1, "wrap lo");
        rdc(llec_pkg::OFS_CTR_HI + 8'h04, 32'h0, "wrap hi");
        // outcome k is sent k+1 times after the non-candidates
        foreach (mlist[m]) begin
            wr(a_lo(2), 32'h0);
            wr(a_sel(2), mk_sel(llec_pkg::EVT_DIRECT_TO_CORE, mlist[m], 0,
                                0));
            for (int j = 0; j < 32; j++)
                if (j[4:2] != 3'h7) ev(2'h0, 5'(j), 2'h0);
            for (int k = 0; k < 4; k++)
                repeat (k + 1) ev(2'h0, {3'h7, oc[k]}, 2'h0);
            ev(2'h0, 5'h0, 2'h0);
            wr(a_sel(2), 32'h0);
            rdc(a_lo(2), mexp[m], "d2c");
        end
        // tx on counters 0-1, rx on 2-3, odd ones count entries
        for (int i = 0; i < 4; i++) begin
            wr(a_lo(i), 32'h0);
            wr(a_sel(i), mk_sel(llec_pkg::EVT_SHUTDOWN_CYCLES,
                8'h01 << (i < 2 ? llec_pkg::SHUT_TX_BIT :
                llec_pkg::SHUT_RX_BIT), 0, i[0]));
        end
        foreach (sseq[j]) ev(2'h0, 5'h0, sseq[j]);
        ev(2'h0, 5'h0, 2'h0);
        for (int i = 0; i < 4; i++) begin
            wr(a_sel(i), 32'h0);
            rdc(a_lo(i), sexp[i], "shutdown");
        end
        conclude();
    end

endmodule

// File: logic/llec_event_counters.sv
// link layer performance event counters with Avalon-MM register access
// ============================================================
//
// The implementer's own choices: the Avalon-MM slave port and the register addresses.
`timescale 1ns/1ps

module llec_event_counters #(
    parameter int CTR_W = 48
) (
    input  wire logic        sys_clk,
    input  wire logic        rst_n,
    input  wire logic [7:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    output logic      [31:0] avs_readdata,
    output logic             avs_waitrequest,
    input  wire logic [1:0]  cluster_trigger_output,
    input  wire logic        pkt_valid,
    input  wire logic        pkt_data_response_class,
    input  wire logic        pkt_to_caching_agent,
    input  wire logic        egress_credits_ok,
    input  wire logic        route_back_table_set,
    input  wire logic        link_shutdown_state_tx,
    input  wire logic        link_shutdown_state_rx
);

    // ========================================================
    // elaboration checks
    if (CTR_W < 33 || CTR_W > 64) begin : g_bad_width
        $error("llec_event_counters: CTR_W must lie in 33..64");
    end

    localparam int NC = llec_pkg::NUM_COUNTERS;

    typedef struct packed {
        logic [NC-1:0][31:0]    sel;
        logic [NC-1:0][CTR_W-1:0] ctr;
        logic [NC-1:0]          prev_lvl;
        logic                   ack;
        logic [31:0]            rdata;
    } llec_state_t;

    llec_state_t st_q;
    llec_state_t st_d;

    // ========================================================
    // per-counter event decode
    // result: [2] level used for edge mode, [1:0] increment
    function automatic logic [2:0] llec_evt(
        input logic [31:0] sel,
        input logic [1:0]  trig,
        input logic        cand,
        input logic        cred,
        input logic        route_back_table,
        input logic        sh_tx,
        input logic        sh_rx,
        input logic        prev
    );
        logic [7:0] code;
        logic [7:0] um;
        logic       extra;
        logic       edge_en;
        logic       lvl;
        logic [1:0] inc;
        logic [3:0] outcome;
        code    = sel[llec_pkg::SEL_CODE_LSB +: 8];
        um      = sel[llec_pkg::SEL_UMASK_LSB +: 8];
        extra   = sel[llec_pkg::SEL_EXTRA_BIT];
        edge_en = sel[llec_pkg::SEL_EDGE_BIT];
        lvl     = 1'b0;
        inc     = 2'd0;
        // the four outcomes exclude one another by construction
        outcome[llec_pkg::D2C_SUCCESS_BIT]    = cand & cred & route_back_table;
        outcome[llec_pkg::D2C_FAIL_CREDIT]    = cand & ~cred & route_back_table;
        outcome[llec_pkg::D2C_FAIL_ROUTE_TBL] = cand & cred & ~route_back_table;
        outcome[llec_pkg::D2C_FAIL_BOTH]      = cand & ~cred & ~route_back_table;
        if (!sel[llec_pkg::SEL_EN_BIT]) begin
            inc = 2'd0;
        end else if (extra) begin
            // trigger count is only reachable with the extra bit
            if (code == llec_pkg::EVT_TRIGGER_OUTPUT) begin
                lvl = &trig;
                if (edge_en) begin
                    inc = {1'b0, lvl & ~prev};
                end else begin
                    inc = {1'b0, trig[0]} + {1'b0, trig[1]};
                end
            end
        end else begin
            case (code)
                llec_pkg::EVT_LINK_CLOCK_TICK: begin
                    inc = 2'd1;
                end
                llec_pkg::EVT_DIRECT_TO_CORE: begin
                    // any selected outcome counts, once per packet
                    inc = {1'b0, |(outcome & um[3:0])};
                end
                llec_pkg::EVT_SHUTDOWN_CYCLES: begin
                    // each direction selected on its own
                    lvl = (sh_tx & um[llec_pkg::SHUT_TX_BIT]) |
                          (sh_rx & um[llec_pkg::SHUT_RX_BIT]);
                    if (edge_en) begin
                        inc = {1'b0, lvl & ~prev};
                    end else begin
                        inc = {1'b0, lvl};
                    end
                end
                default: begin
                    inc = 2'd0;
                end
            endcase
        end
        return {lvl, inc};
    endfunction

    // ========================================================
    // event sources; all on the link-layer clock, no crossing
    // sys_clk is the link-layer clock, one eighth of the transfer
    // rate; the rate never changes so a tick is a fixed time
    logic        d2c_cand;
    logic [NC-1:0][2:0] evt;

    assign d2c_cand = pkt_valid & pkt_data_response_class &
                      pkt_to_caching_agent;

    for (genvar i = 0; i < NC; i++) begin : g_evt
        assign evt[i] = llec_evt(st_q.sel[i], cluster_trigger_output,
                                 d2c_cand, egress_credits_ok,
                                 route_back_table_set,
                                 link_shutdown_state_tx,
                                 link_shutdown_state_rx,
                                 st_q.prev_lvl[i]);
    end

    // ========================================================
    // Avalon-MM slave: one wait cycle on every access
    logic       bus_take;
    logic [5:0] widx;
    logic [NC-1:0] wr_sel;
    logic [NC-1:0] wr_lo;
    logic [NC-1:0] wr_hi;

    assign avs_waitrequest = (avs_read | avs_write) & ~st_q.ack;
    assign bus_take        = (avs_read | avs_write) & ~st_q.ack;
    assign widx            = avs_address[7:2];
    assign avs_readdata    = st_q.rdata;

    always_comb begin
        for (int i = 0; i < NC; i++) begin
            wr_sel[i] = bus_take & avs_write &
                        (widx == 6'(llec_pkg::OFS_SEL_BASE[7:2] + i));
            wr_lo[i]  = bus_take & avs_write &
                        (widx == 6'(llec_pkg::OFS_CTR_LO[7:2] + i));
            wr_hi[i]  = bus_take & avs_write &
                        (widx == 6'(llec_pkg::OFS_CTR_HI[7:2] + i));
        end
    end

    // ========================================================
    // next state
    always_comb begin
        logic [CTR_W-1:0] c;
        logic [31:0]      rd;
        logic [63:0]      wide;
        c    = '0;
        rd   = 32'h0000_0000;
        wide = 64'h0;
        st_d = st_q;
        st_d.ack = bus_take;
        for (int i = 0; i < NC; i++) begin
            st_d.prev_lvl[i] = evt[i][2];
            // wraps silently at the counter width
            c = st_q.ctr[i] + CTR_W'(evt[i][1:0]);
            wide = 64'(c);
            if (wr_lo[i]) begin
                wide[31:0] = avs_writedata;
            end
            if (wr_hi[i]) begin
                wide[63:32] = avs_writedata;
            end
            st_d.ctr[i] = wide[CTR_W-1:0];
            if (wr_sel[i]) begin
                st_d.sel[i] = avs_writedata & llec_pkg::SEL_WR_MASK;
            end
        end
        if (bus_take && avs_read) begin
            for (int i = 0; i < NC; i++) begin
                wide = 64'(st_q.ctr[i]);
                if (widx == 6'(llec_pkg::OFS_SEL_BASE[7:2] + i)) begin
                    rd = st_q.sel[i];
                end else if (widx ==
                             6'(llec_pkg::OFS_CTR_LO[7:2] + i)) begin
                    rd = wide[31:0];
                end else if (widx ==
                             6'(llec_pkg::OFS_CTR_HI[7:2] + i)) begin
                    rd = wide[63:32];
                end
            end
            if (widx == llec_pkg::OFS_INFO[7:2]) begin
                rd = {16'h0000, 8'(CTR_W), llec_pkg::LINK_CLK_DIV};
            end
        end
        // unmapped reads return zero
        st_d.rdata = (bus_take && avs_read) ? rd : st_q.rdata;
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            st_q.sel      <= {NC{llec_pkg::SEL_RESET}};
            st_q.ctr      <= {NC{CTR_W'(llec_pkg::CTR_RESET)}};
            st_q.prev_lvl <= '0;
            st_q.ack      <= 1'b0;
            st_q.rdata    <= 32'h0000_0000;
        end else begin
            st_q <= st_d;
        end
    end

    // ========================================================
    // checks
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);

    logic [NC-1:0] quiet;
    logic [7:0]    code0;
    logic [7:0]    code1;
    logic [7:0]    code2;
    logic [7:0]    code3;
    always_comb begin
        for (int i = 0; i < NC; i++) begin
            quiet[i] = ~wr_lo[i] & ~wr_hi[i] &
                       st_q.sel[i][llec_pkg::SEL_EN_BIT];
        end
    end
    assign code0 = st_q.sel[0][7:0];
    assign code1 = st_q.sel[1][7:0];
    assign code2 = st_q.sel[2][7:0];
    assign code3 = st_q.sel[3][7:0];

    AST_TICK_INC: assert property (
        quiet[0] && code0 == llec_pkg::EVT_LINK_CLOCK_TICK &&
        !st_q.sel[0][llec_pkg::SEL_EXTRA_BIT]
        |=> st_q.ctr[0] == CTR_W'($past(st_q.ctr[0]) + 1))
        else $error("tick counter did not advance by one");

    AST_TRIG_SUM: assert property (
        quiet[1] && code1 == llec_pkg::EVT_TRIGGER_OUTPUT &&
        st_q.sel[1][llec_pkg::SEL_EXTRA_BIT] &&
        !st_q.sel[1][llec_pkg::SEL_EDGE_BIT]
        |=> st_q.ctr[1] == CTR_W'($past(st_q.ctr[1]) +
            $countones($past(cluster_trigger_output))))
        else $error("trigger count not equal to active slots");

    AST_TRIG_EDGE: assert property (
        quiet[1] && code1 == llec_pkg::EVT_TRIGGER_OUTPUT &&
        st_q.sel[1][llec_pkg::SEL_EXTRA_BIT] &&
        st_q.sel[1][llec_pkg::SEL_EDGE_BIT] &&
        (&cluster_trigger_output) ##1
        quiet[1] && $stable(st_q.sel[1]) && (&cluster_trigger_output)
        |=> st_q.ctr[1] == $past(st_q.ctr[1]))
        else $error("held both-trigger counted twice in edge mode");

    AST_D2C_NONCAND: assert property (
        quiet[2] && code2 == llec_pkg::EVT_DIRECT_TO_CORE &&
        !st_q.sel[2][llec_pkg::SEL_EXTRA_BIT] &&
        !(pkt_valid && pkt_data_response_class && pkt_to_caching_agent)
        |=> st_q.ctr[2] == $past(st_q.ctr[2]))
        else $error("direct-to-core counted a non-candidate");

    AST_D2C_SUCCESS: assert property (
        quiet[2] && code2 == llec_pkg::EVT_DIRECT_TO_CORE &&
        st_q.sel[2][15:8] == 8'h01 && d2c_cand &&
        egress_credits_ok && route_back_table_set
        |=> st_q.ctr[2] == CTR_W'($past(st_q.ctr[2]) + 1))
        else $error("successful spawn not counted");

    AST_D2C_CREDIT: assert property (
        quiet[2] && code2 == llec_pkg::EVT_DIRECT_TO_CORE &&
        st_q.sel[2][15:8] == 8'h02 && d2c_cand &&
        (egress_credits_ok || !route_back_table_set)
        |=> st_q.ctr[2] == $past(st_q.ctr[2]))
        else $error("credit failure counted a wrong outcome");

    AST_D2C_ROUTE: assert property (
        quiet[2] && code2 == llec_pkg::EVT_DIRECT_TO_CORE &&
        st_q.sel[2][15:8] == 8'h04 && d2c_cand &&
        egress_credits_ok && !route_back_table_set
        |=> st_q.ctr[2] == CTR_W'($past(st_q.ctr[2]) + 1))
        else $error("route table failure not counted");

    AST_D2C_BOTH: assert property (
        quiet[2] && code2 == llec_pkg::EVT_DIRECT_TO_CORE &&
        st_q.sel[2][15:8] == 8'h08 && d2c_cand &&
        !egress_credits_ok && !route_back_table_set
        |=> st_q.ctr[2] == CTR_W'($past(st_q.ctr[2]) + 1))
        else $error("combined failure not counted");

    AST_D2C_ANY: assert property (
        quiet[2] && code2 == llec_pkg::EVT_DIRECT_TO_CORE &&
        !st_q.sel[2][llec_pkg::SEL_EXTRA_BIT] &&
        st_q.sel[2][15:8] == 8'h0f && d2c_cand
        |=> st_q.ctr[2] == CTR_W'($past(st_q.ctr[2]) + 1))
        else $error("any-outcome mask did not count the attempt");

    AST_SHUT_CYCLES: assert property (
        quiet[0] && code0 == llec_pkg::EVT_SHUTDOWN_CYCLES &&
        st_q.sel[0][15:8] == 8'h01 &&
        !st_q.sel[0][llec_pkg::SEL_EDGE_BIT] &&
        !st_q.sel[0][llec_pkg::SEL_EXTRA_BIT]
        |=> st_q.ctr[0] == CTR_W'($past(st_q.ctr[0]) +
            $past(link_shutdown_state_tx)))
        else $error("shutdown cycles miscounted for tx");

    AST_SHUT_ENTRY: assert property (
        quiet[3] && code3 == llec_pkg::EVT_SHUTDOWN_CYCLES &&
        st_q.sel[3][15:8] == 8'h02 && st_q.sel[3][18] &&
        !st_q.sel[3][llec_pkg::SEL_EXTRA_BIT] &&
        link_shutdown_state_rx && !st_q.prev_lvl[3]
        |=> st_q.ctr[3] == CTR_W'($past(st_q.ctr[3]) + 1))
        else $error("shutdown entry not counted once");

    AST_BUS_ANSWER: assert property (
        (avs_read || avs_write) && !st_q.ack
        |-> avs_waitrequest ##1 !avs_waitrequest)
        else $error("bus access not answered after one wait cycle");

endmodule

// File: logic/llec_pkg.sv
// constants shared by the link layer event counter block
package llec_pkg;

    // ========================================================
    // register byte offsets (Avalon-MM, one 32-bit word each)
    localparam logic [7:0] OFS_SEL_BASE   = 8'h00;
    localparam logic [7:0] OFS_CTR_LO     = 8'h10;
    localparam logic [7:0] OFS_CTR_HI     = 8'h20;
    localparam logic [7:0] OFS_INFO       = 8'h30;

    // ========================================================
    // event select register fields
    localparam int SEL_CODE_LSB  = 0;
    localparam int SEL_UMASK_LSB = 8;
    localparam int SEL_EXTRA_BIT = 16;
    localparam int SEL_EDGE_BIT  = 18;
    localparam int SEL_EN_BIT    = 22;
    localparam logic [31:0] SEL_WR_MASK  = 32'h0045_ffff;
    localparam logic [31:0] SEL_RESET    = 32'h0000_0000;
    localparam logic [47:0] CTR_RESET    = 48'h0000_0000_0000;

    // ========================================================
    // event codes
    localparam logic [7:0] EVT_SHUTDOWN_CYCLES = 8'h12;
    localparam logic [7:0] EVT_DIRECT_TO_CORE  = 8'h13;
    localparam logic [7:0] EVT_LINK_CLOCK_TICK = 8'h14;
    localparam logic [7:0] EVT_TRIGGER_OUTPUT  = 8'h38;

    // direct-to-core outcome mask bits
    localparam int D2C_SUCCESS_BIT    = 0;
    localparam int D2C_FAIL_CREDIT    = 1;
    localparam int D2C_FAIL_ROUTE_TBL = 2;
    localparam int D2C_FAIL_BOTH      = 3;

    // shutdown event direction mask bits
    localparam int SHUT_TX_BIT = 0;
    localparam int SHUT_RX_BIT = 1;

    // ========================================================
    // link-layer clock is the transfer rate divided by this
    localparam logic [7:0] LINK_CLK_DIV    = 8'h08;
    localparam int         NUM_COUNTERS    = 4;
    localparam int         NUM_TRIG_SLOTS  = 2;

endpackage
